// ### inc/ppc_pkg.sv
// Purpose: Shared constants and width check of the programmed-I/O completer
// Assumes: 64-bit request and completion streams, 250 MHz user clock
// Notes:   Stream layouts are the core's descriptor layouts cut to 64 bits
package ppc_pkg;
   // ==========================================================
   // Build selection
   // ==========================================================
   localparam int unsigned PPC_STREAM_W = 64;
   localparam int unsigned PPC_LANES    = 8;
   localparam bit          PPC_GEN3_500 = 1'b0;   // 8.0 Gb/s link at 500 MHz user clock

   // Width allowed for a lane count; 128 bits is barred on x8 at 500 MHz
   function automatic bit ppc_width_ok(input int unsigned w, input int unsigned lanes,
                                       input bit gen3_500);
      bit ok;
      ok = (w == 64);
      if (lanes >= 2 && w == 128) ok = !(lanes == 8 && gen3_500);
      if (lanes >= 4 && w == 256) ok = 1'b1;
      return ok;
   endfunction : ppc_width_ok

   // ==========================================================
   // Memory geometry
   // ==========================================================
   localparam int unsigned PPC_REGIONS    = 4;
   localparam int unsigned PPC_WORD_AW    = 9;     // 512 Dwords = 2 KB
   localparam int unsigned PPC_WORDS      = 512;
   localparam int unsigned PPC_SPACE_BYTE = 8192;

   // Region index per hit aperture id
   localparam logic [2:0] PPC_HIT_FIRST  = 3'h0;
   localparam logic [2:0] PPC_HIT_WIDE   = 3'h1;
   localparam logic [2:0] PPC_HIT_NARROW = 3'h2;
   localparam logic [2:0] PPC_HIT_ROM    = 3'h6;
   localparam logic [1:0] PPC_RGN_FIRST  = 2'h0;
   localparam logic [1:0] PPC_RGN_WIDE   = 2'h1;
   localparam logic [1:0] PPC_RGN_NARROW = 2'h2;
   localparam logic [1:0] PPC_RGN_ROM    = 2'h3;

   // ==========================================================
   // Request descriptor fields (beat 1 holds bits 127:64)
   // ==========================================================
   localparam int unsigned PPC_RQ_DCNT_LSB = 0;    // 11 bits
   localparam int unsigned PPC_RQ_TYPE_LSB = 11;   // 4 bits
   localparam int unsigned PPC_RQ_RID_LSB  = 16;   // 16 bits
   localparam int unsigned PPC_RQ_TAG_LSB  = 32;   // 8 bits
   localparam int unsigned PPC_RQ_HIT_LSB  = 48;   // 3 bits
   localparam int unsigned PPC_RQ_TC_LSB   = 57;   // 3 bits
   localparam int unsigned PPC_RQ_ATTR_LSB = 60;   // 3 bits

   localparam logic [3:0] PPC_REQ_MEM_RD = 4'h0;
   localparam logic [3:0] PPC_REQ_MEM_WR = 4'h1;
   localparam logic [3:0] PPC_REQ_IO_RD  = 4'h2;
   localparam logic [3:0] PPC_REQ_IO_WR  = 4'h3;
   localparam logic [10:0] PPC_ONE_DWORD = 11'h001;

   // ==========================================================
   // Trigger writes to the first region
   // ==========================================================
   localparam logic [10:0] PPC_OFS_MRD    = 11'hea8;
   localparam logic [10:0] PPC_OFS_INTR   = 11'heec;
   localparam logic [31:0] PPC_KEY_MRD    = 32'haaaa_bbbb;
   localparam logic [31:0] PPC_KEY_LEGACY = 32'hcccc_dddd;
   localparam logic [31:0] PPC_KEY_MSI    = 32'heeee_ffff;
   localparam logic [31:0] PPC_KEY_MSIX   = 32'hdead_beef;

   // ==========================================================
   // Completion descriptor values
   // ==========================================================
   localparam logic [2:0]  PPC_CPL_OK     = 3'h0;
   localparam logic [12:0] PPC_CPL_BYTES  = 13'h0004;
   localparam logic [15:0] PPC_CPLR_ID    = 16'h0000;  // Arbitrary completer id
   localparam logic [1:0]  PPC_KEEP_DESC  = 2'h1;
   localparam logic [1:0]  PPC_KEEP_FULL  = 2'h3;
endpackage : ppc_pkg

// ### hdl/ppc_region_mem.sv
// Purpose: One 2 KB dual-port region, write port and registered read port
// Assumes: Write and read never collide on the same cycle (caller serialises)
// Notes:   Storage is flip-flops; write_busy marks the cycle after a write
`timescale 1ns/1ps
module ppc_region_mem
   import ppc_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   reset_n,
   input  wire logic                   wr_en,
   input  wire logic [PPC_WORD_AW-1:0] wr_idx,
   input  wire logic [3:0]             wr_be,
   input  wire logic [31:0]            wr_data,
   input  wire logic                   rd_en,
   input  wire logic [PPC_WORD_AW-1:0] rd_idx,
   output logic      [31:0]            rd_data,
   output logic                        write_busy
);
   logic [31:0] mem_r [PPC_WORDS];

   // ==========================================================
   // Write port, byte lanes
   // ==========================================================
   // Unreset array; one process for all lanes keeps a single writer
   always_ff @(posedge ref_clk) begin
      for (int b = 0; b < 4; b++) begin
         if (wr_en && wr_be[b]) begin
            mem_r[wr_idx][8*b +: 8] <= wr_data[8*b +: 8];
         end
      end
   end

   // Pending flag seen by the request engine
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         write_busy <= 1'b0;
      end else begin
         write_busy <= wr_en;
      end
   end

   // ==========================================================
   // Read port, one cycle latency
   // ==========================================================
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 32'h0000_0000;
      end else if (rd_en) begin
         rd_data <= mem_r[rd_idx];
      end
   end
endmodule : ppc_region_mem

// ### hdl/ppc_cpl_tx.sv
// Purpose: Builds one completion as two 64-bit beats on the completion stream
// Assumes: start only while idle; fields stable from start to sent pulse
// Notes:   Beat 1 carries the payload Dword only when has_data is set
`timescale 1ns/1ps
module ppc_cpl_tx
   import ppc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        start,
   input  wire logic        has_data,
   input  wire logic [6:0]  lower_addr,
   input  wire logic [15:0] req_id,
   input  wire logic [7:0]  tag,
   input  wire logic [2:0]  tc,
   input  wire logic [2:0]  attr,
   input  wire logic [31:0] data,
   output logic      [63:0] cc_tdata,
   output logic      [1:0]  cc_tkeep,
   output logic             cc_tlast,
   output logic             cc_tvalid,
   input  wire logic        cc_tready,
   output logic             completion_sent_pulse
);
   logic [95:0] desc;
   logic        beat_r;

   // Descriptor: address, count, status, echoed requester fields
   assign desc = {1'b0, attr, tc, 1'b0, PPC_CPLR_ID, tag, req_id, 2'h0, PPC_CPL_OK,
                  10'h000, has_data, 3'h0, PPC_CPL_BYTES, 9'h000, lower_addr};

   // ==========================================================
   // Beat sequencer
   // ==========================================================
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cc_tvalid             <= 1'b0;
         cc_tdata              <= 64'h0;
         cc_tkeep              <= 2'h0;
         cc_tlast              <= 1'b0;
         beat_r                <= 1'b0;
         completion_sent_pulse <= 1'b0;
      end else begin
         completion_sent_pulse <= 1'b0;
         if (start && !cc_tvalid) begin
            cc_tvalid <= 1'b1;
            cc_tdata  <= desc[63:0];
            cc_tkeep  <= PPC_KEEP_FULL;
            cc_tlast  <= 1'b0;
            beat_r    <= 1'b0;
         end else if (cc_tvalid && cc_tready) begin
            if (!beat_r) begin
               beat_r   <= 1'b1;
               cc_tdata <= {data, desc[95:64]};
               cc_tkeep <= has_data ? PPC_KEEP_FULL : PPC_KEEP_DESC;
               cc_tlast <= 1'b1;
            end else begin
               cc_tvalid             <= 1'b0;
               cc_tlast              <= 1'b0;
               completion_sent_pulse <= 1'b1;
            end
         end
      end
   end
endmodule : ppc_cpl_tx

// ### hdl/ppc_completer.sv
// Purpose: Programmed-I/O completer behind the endpoint's request and completion streams
// Assumes: Request stream, 64 bits: beat 0 address, beat 1 descriptor high, beat 2 payload
// Notes:   One request in flight; the stream is stalled while it is served
`timescale 1ns/1ps
module ppc_completer
   import ppc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic [63:0] cq_tdata,
   input  wire logic [3:0]  cq_first_be,
   input  wire logic        cq_tlast,
   input  wire logic        cq_tvalid,
   output logic             completer_request_ready_out,
   output logic      [63:0] cc_tdata,
   output logic      [1:0]  cc_tkeep,
   output logic             cc_tlast,
   output logic             cc_tvalid,
   input  wire logic        cc_tready,
   input  wire logic        io_space_enable,
   output logic             mem_read_start_pulse,
   output logic             legacy_intr_pulse,
   output logic             msi_pulse,
   output logic             msix_pulse,
   output logic             datapath_ok
);
   // ==========================================================
   // Declarations
   // ==========================================================
   typedef enum logic [2:0] {
      ST_IDLE, ST_DESC_HI, ST_PAYLOAD, ST_DRAIN, ST_WRITE, ST_WR_WAIT, ST_READ, ST_CPL
   } ppc_state_type;

   ppc_state_type    state_r;
   ppc_state_type    state_nxt;
   logic [10:0]      addr_r;
   logic [3:0]       be_r;
   logic [1:0]       rgn_r;
   logic             is_io_r;
   logic [31:0]      wdata_r;
   logic [15:0]      rid_r;
   logic [7:0]       tag_r;
   logic [2:0]       tc_r;
   logic [2:0]       attr_r;
   logic [3:0]       rd_en_sel;
   logic [3:0]       wr_en_sel;
   logic [3:0]       busy_vec;
   logic [31:0]      rdata_vec [PPC_REGIONS];
   logic             ram_write_pending;
   logic             completion_sent_pulse;
   logic             cpl_start;
   logic             cpl_has_data;
   logic             rd_issued_r;
   logic             take;

   // Beat 1 field views
   logic [10:0] d_cnt;
   logic [3:0]  d_type;
   logic [2:0]  d_hit;
   logic [1:0]  d_rgn;
   logic        d_rgn_ok;
   logic        d_io;
   logic        d_wr;
   logic        d_ok;

   assign take          = cq_tvalid && completer_request_ready_out;
   assign d_cnt         = cq_tdata[PPC_RQ_DCNT_LSB +: 11];
   assign d_type        = cq_tdata[PPC_RQ_TYPE_LSB +: 4];
   assign d_hit         = cq_tdata[PPC_RQ_HIT_LSB +: 3];
   assign d_io          = (d_type == PPC_REQ_IO_RD) || (d_type == PPC_REQ_IO_WR);
   assign d_wr          = (d_type == PPC_REQ_MEM_WR) || (d_type == PPC_REQ_IO_WR);
   assign datapath_ok   = ppc_width_ok(PPC_STREAM_W, PPC_LANES, PPC_GEN3_500);

   // ==========================================================
   // Aperture decode
   // ==========================================================
   // Only the first space of each kind exists; any other hit is dropped
   always_comb begin
      d_rgn    = PPC_RGN_FIRST;
      d_rgn_ok = 1'b1;
      unique case (d_hit)
         PPC_HIT_FIRST:  d_rgn = PPC_RGN_FIRST;
         PPC_HIT_WIDE:   d_rgn = PPC_RGN_WIDE;
         PPC_HIT_NARROW: d_rgn = PPC_RGN_NARROW;
         PPC_HIT_ROM:    d_rgn = PPC_RGN_ROM;
         default:        d_rgn_ok = 1'b0;
      endcase
   end

   // Request is served only if one Dword, known type, and I/O allowed
   assign d_ok = d_rgn_ok && (d_cnt == PPC_ONE_DWORD)
              && (d_type <= PPC_REQ_IO_WR) && (!d_io || io_space_enable);

   // ==========================================================
   // Request state machine
   // ==========================================================
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (take) state_nxt = cq_tlast ? ST_IDLE : ST_DESC_HI;
         end
         ST_DESC_HI: begin
            if (take) begin
               if (!d_ok) state_nxt = cq_tlast ? ST_IDLE : ST_DRAIN;
               else if (d_wr) state_nxt = cq_tlast ? ST_IDLE : ST_PAYLOAD;
               else state_nxt = cq_tlast ? ST_READ : ST_DRAIN;
            end
         end
         ST_PAYLOAD: begin
            if (take) state_nxt = cq_tlast ? ST_WRITE : ST_DRAIN;
         end
         ST_DRAIN: begin
            if (take && cq_tlast) state_nxt = ST_IDLE;
         end
         ST_WRITE: begin
            state_nxt = ST_WR_WAIT;
         end
         ST_WR_WAIT: begin
            if (!ram_write_pending) state_nxt = is_io_r ? ST_CPL : ST_IDLE;
         end
         ST_READ: begin
            if (rd_issued_r) state_nxt = ST_CPL;
         end
         ST_CPL: begin
            if (completion_sent_pulse) state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Ready only while taking beats; low through write, read and completion
   assign completer_request_ready_out = (state_r == ST_IDLE) || (state_r == ST_DESC_HI)
                                      || (state_r == ST_PAYLOAD) || (state_r == ST_DRAIN);

   // ==========================================================
   // Captured request fields
   // ==========================================================
   // Region is latched with the descriptor, before any enable
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_r  <= 11'h000;
         be_r    <= 4'h0;
         rgn_r   <= PPC_RGN_FIRST;
         is_io_r <= 1'b0;
         rid_r   <= 16'h0000;
         tag_r   <= 8'h00;
         tc_r    <= 3'h0;
         attr_r  <= 3'h0;
      end else if (take && state_r == ST_IDLE) begin
         addr_r <= cq_tdata[10:0];
         be_r   <= cq_first_be;
      end else if (take && state_r == ST_DESC_HI) begin
         rgn_r   <= d_rgn;
         is_io_r <= d_io;
         rid_r   <= cq_tdata[PPC_RQ_RID_LSB +: 16];
         tag_r   <= cq_tdata[PPC_RQ_TAG_LSB +: 8];
         tc_r    <= cq_tdata[PPC_RQ_TC_LSB +: 3];
         attr_r  <= cq_tdata[PPC_RQ_ATTR_LSB +: 3];
      end
   end

   // Write payload Dword
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wdata_r <= 32'h0000_0000;
      end else if (take && state_r == ST_PAYLOAD) begin
         wdata_r <= cq_tdata[31:0];
      end
   end

   // Read enable is a single cycle; data is ready the cycle after
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_issued_r <= 1'b0;
      end else begin
         rd_issued_r <= (state_r == ST_READ) && !rd_issued_r;
      end
   end

   // ==========================================================
   // Four regions
   // ==========================================================
   for (genvar r = 0; r < PPC_REGIONS; r++) begin : g_rgn
      assign wr_en_sel[r] = (state_r == ST_WRITE) && (rgn_r == 2'(r));
      assign rd_en_sel[r] = (state_r == ST_READ) && !rd_issued_r && (rgn_r == 2'(r));
      ppc_region_mem u_mem (
         .ref_clk    (ref_clk),
         .reset_n    (reset_n),
         .wr_en      (wr_en_sel[r]),
         .wr_idx     (addr_r[10:2]),
         .wr_be      (is_io_r ? 4'hf : be_r),
         .wr_data    (wdata_r),
         .rd_en      (rd_en_sel[r]),
         .rd_idx     (addr_r[10:2]),
         .rd_data    (rdata_vec[r]),
         .write_busy (busy_vec[r])
      );
   end

   assign ram_write_pending = |busy_vec;

   // ==========================================================
   // Trigger writes to the first region
   // ==========================================================
   // Triggers still store the payload; the pulse is a side effect only
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_read_start_pulse <= 1'b0;
         legacy_intr_pulse    <= 1'b0;
         msi_pulse            <= 1'b0;
         msix_pulse           <= 1'b0;
      end else begin
         mem_read_start_pulse <= wr_en_sel[PPC_RGN_FIRST] && addr_r == PPC_OFS_MRD
                                 && wdata_r == PPC_KEY_MRD;
         legacy_intr_pulse    <= wr_en_sel[PPC_RGN_FIRST] && addr_r == PPC_OFS_INTR
                                 && wdata_r == PPC_KEY_LEGACY;
         msi_pulse            <= wr_en_sel[PPC_RGN_FIRST] && addr_r == PPC_OFS_INTR
                                 && wdata_r == PPC_KEY_MSI;
         msix_pulse           <= wr_en_sel[PPC_RGN_FIRST] && addr_r == PPC_OFS_INTR
                                 && wdata_r == PPC_KEY_MSIX;
      end
   end

   // ==========================================================
   // Completion launch
   // ==========================================================
   // Reads launch when data lands; I/O writes when the write has settled
   assign cpl_start    = (state_r == ST_READ && rd_issued_r)
                      || (state_r == ST_WR_WAIT && !ram_write_pending && is_io_r);
   assign cpl_has_data = (state_r == ST_READ);

   // Payload held in flops for the whole completion
   logic [31:0] cpl_data_r;
   logic        cpl_dflag_r;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cpl_data_r  <= 32'h0000_0000;
         cpl_dflag_r <= 1'b0;
      end else if (cpl_start) begin
         cpl_data_r  <= cpl_has_data ? rdata_vec[rgn_r] : 32'h0000_0000;
         cpl_dflag_r <= cpl_has_data;
      end
   end

   logic cpl_go_r;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cpl_go_r <= 1'b0;
      end else begin
         cpl_go_r <= cpl_start;
      end
   end

   // Lower address from Dword address and first enabled byte; zero for I/O requests
   logic [1:0] lo_byte;
   always_comb begin
      lo_byte = 2'h0;
      if (!be_r[0]) lo_byte = 2'h1;
      if (!be_r[0] && !be_r[1]) lo_byte = 2'h2;
      if (!be_r[0] && !be_r[1] && !be_r[2]) lo_byte = 2'h3;
   end

   ppc_cpl_tx u_cpl (
      .ref_clk               (ref_clk),
      .reset_n               (reset_n),
      .start                 (cpl_go_r),
      .has_data              (cpl_dflag_r),
      .lower_addr            (is_io_r ? 7'h00 : {addr_r[6:2], lo_byte}),
      .req_id                (rid_r),
      .tag                   (tag_r),
      .tc                    (tc_r),
      .attr                  (attr_r),
      .data                  (cpl_data_r),
      .cc_tdata              (cc_tdata),
      .cc_tkeep              (cc_tkeep),
      .cc_tlast              (cc_tlast),
      .cc_tvalid             (cc_tvalid),
      .cc_tready             (cc_tready),
      .completion_sent_pulse (completion_sent_pulse)
   );
endmodule : ppc_completer

// ### bench/ppc_chk_monitor.sv
// Purpose: Port assertions on the completer
// Assumes: Bound onto ppc_completer, one clock
// Notes:   Watches what the design drives, plus cc_tready from the core
`timescale 1ns/1ps
module ppc_chk_monitor
   import ppc_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic        completer_request_ready_out,
   input wire logic [63:0] cc_tdata,
   input wire logic [1:0]  cc_tkeep,
   input wire logic        cc_tlast,
   input wire logic        cc_tvalid,
   input wire logic        cc_tready,
   input wire logic        mem_read_start_pulse,
   input wire logic        legacy_intr_pulse,
   input wire logic        msi_pulse,
   input wire logic        msix_pulse,
   input wire logic        datapath_ok
);
   // ==========================================================
   // Stream, trigger and build checks
   // ==========================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic [3:0] pulses;
   // Gathered so exclusivity is one check
   assign pulses = {mem_read_start_pulse, legacy_intr_pulse, msi_pulse, msix_pulse};
   chk_ready_cpl_low: assert property (cc_tvalid |-> !completer_request_ready_out)
      else $error("ready high in completion");
   chk_ready_before_cpl: assert property ($rose(cc_tvalid) |-> !$past(completer_request_ready_out, 3))
      else $error("ready high before completion");
   chk_cpl_hold: assert property (cc_tvalid && !cc_tready |=> cc_tvalid && $stable(cc_tdata))
      else $error("beat changed while stalled");
   chk_cpl_tail: assert property (cc_tvalid && cc_tready && !cc_tlast |=> ##[0:8] cc_tvalid && cc_tlast)
      else $error("second beat missing");
   chk_head_fields: assert property (cc_tvalid && !cc_tlast |-> cc_tkeep == PPC_KEEP_FULL
      && cc_tdata[28:16] == PPC_CPL_BYTES && cc_tdata[45:43] == PPC_CPL_OK) else $error("bad completion head");
   chk_nodata_keep: assert property (cc_tvalid && cc_tready && !cc_tlast && cc_tdata[42:32] == 11'h000
      |=> ##[0:8] cc_tvalid && cc_tlast && cc_tkeep == PPC_KEEP_DESC) else $error("bad keep without data");
   chk_pulse_excl: assert property ($onehot0(pulses))
      else $error("two pulses at once");
   chk_pulse_short: assert property (|pulses |=> pulses == 4'h0)
      else $error("pulse too long");
   chk_pulse_stall: assert property (|pulses |-> !completer_request_ready_out)
      else $error("ready high in write");
   chk_width_ok: assert property (datapath_ok)
      else $error("bad datapath build");
   cover property (cc_tvalid && cc_tready && cc_tlast && cc_tkeep == PPC_KEEP_FULL);
   cover property (cc_tvalid && cc_tready && cc_tlast && cc_tkeep == PPC_KEEP_DESC);
   cover property (msix_pulse);
endmodule : ppc_chk_monitor

// ### bench/ppc_core_model.sv
// Purpose: Endpoint-core side of the completion stream
// Assumes: Back-pressure at random; two beats per completion
// Notes:   Request side is driven by the bench tasks
`timescale 1ns/1ps
module ppc_core_model
   import ppc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic [63:0] cc_tdata,
   input  wire logic [1:0]  cc_tkeep,
   input  wire logic        cc_tlast,
   input  wire logic        cc_tvalid,
   output logic             cc_tready,
   output logic      [7:0]  ncpl,
   output logic      [63:0] desc_r,
   output logic      [63:0] beat1_r,
   output logic      [1:0]  keep1_r
);
   // Stalls change off the sampling edge, forcing held beats
   initial cc_tready = 1'b0;
   always @(negedge ref_clk) cc_tready <= ($urandom_range(0, 2) != 0);
   // A completion counts on its last beat
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ncpl <= 8'h00;
      end else if (cc_tvalid && cc_tready && cc_tlast) begin
         ncpl <= ncpl + 8'h01;
         beat1_r <= cc_tdata;
         keep1_r <= cc_tkeep;
      end else if (cc_tvalid && cc_tready) begin
         desc_r <= cc_tdata;
      end
   end
endmodule : ppc_core_model

// ### bench/tb_top.sv
// Purpose: Self-checking bench of the completer
// Assumes: Completion side played by ppc_core_model
// Notes:   Seeded random data plus drop and trigger corners
`timescale 1ns/1ps
module tb_top;
   import ppc_pkg::*;
   logic        ref_clk, reset_n, cq_tlast, cq_tvalid, io_en, rdy, cc_tready, cc_tvalid, cc_tlast, dp_ok;
   logic [63:0] cq_tdata, cc_tdata, desc, beat1;
   logic [1:0]  cc_tkeep, keep1;
   logic [7:0]  ncpl, n0;
   logic [3:0]  pul;
   logic [8:0]  idx;
   logic [13:0] a;
   logic [31:0] s;
   logic [2:0]  hits [4] = '{PPC_HIT_FIRST, PPC_HIT_WIDE, PPC_HIT_NARROW, PPC_HIT_ROM};
   logic [10:0] offs [4] = '{PPC_OFS_MRD, PPC_OFS_INTR, PPC_OFS_INTR, PPC_OFS_INTR};
   logic [31:0] keys [4] = '{PPC_KEY_MRD, PPC_KEY_LEGACY, PPC_KEY_MSI, PPC_KEY_MSIX};
   int          pc [4] = '{0, 0, 0, 0};
   int          miscompares = 0, tests_run = 0;
   ppc_completer uut (.ref_clk, .reset_n, .cq_tdata, .cq_first_be(4'hf), .cq_tlast, .cq_tvalid,
      .completer_request_ready_out(rdy), .cc_tdata, .cc_tkeep, .cc_tlast, .cc_tvalid, .cc_tready,
      .io_space_enable(io_en), .mem_read_start_pulse(pul[3]), .legacy_intr_pulse(pul[2]),
      .msi_pulse(pul[1]), .msix_pulse(pul[0]), .datapath_ok(dp_ok));
   ppc_core_model core (.ref_clk, .reset_n, .cc_tdata, .cc_tkeep, .cc_tlast, .cc_tvalid, .cc_tready, .ncpl,
      .desc_r(desc), .beat1_r(beat1), .keep1_r(keep1));
   // Clock and trigger pulse tally
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) for (int k = 0; k < 4; k++) if (pul[3-k] === 1'b1) pc[k]++;
   function automatic logic [31:0] pat(input logic [2:0] h, input logic [31:0] v);
      return v ^ {h, 29'h0};
   endfunction : pat
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   // Beat held until ready takes it
   task automatic beat(input logic [63:0] d, input logic l);
      cq_tdata = d;
      cq_tlast = l;
      cq_tvalid = 1'b1;
      while (rdy !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
   endtask : beat
   task automatic req(input logic [3:0] t, input logic [2:0] h, input logic [13:0] ad, input logic [10:0] dc,
                      input logic [31:0] d, input logic [7:0] tg);
      beat(64'(ad), 1'b0);
      beat(64'(dc) | 64'(t) << PPC_RQ_TYPE_LSB | 64'({~tg, tg}) << PPC_RQ_RID_LSB | 64'(tg[5:0]) << PPC_RQ_TC_LSB
           | 64'(tg) << PPC_RQ_TAG_LSB | 64'(h) << PPC_RQ_HIT_LSB, !t[0]);
      if (t[0]) beat(64'(d), 1'b1);
      cq_tvalid = 1'b0;
      @(negedge ref_clk);
   endtask : req
   task automatic wcpl();
      for (int i = 0; i < 60 && ncpl === n0; i++) @(negedge ref_clk);
   endtask : wcpl
   task automatic rd(input logic [3:0] t, input logic [2:0] h, input logic [13:0] ad, input logic [31:0] e);
      logic [7:0] tg;
      tg = 8'($urandom);
      n0 = ncpl;
      req(t, h, ad, PPC_ONE_DWORD, 32'h0, tg);
      wcpl();
      chk("cpl count", 64'(ncpl - n0), 64'h1);
      chk("rd data", 64'(beat1[63:32]), 64'(e));
      chk("rd keep", 64'(keep1), 64'(PPC_KEEP_FULL));
      chk("echo", 64'({desc[63:48], beat1[31:0]}), 64'({~tg, tg, 1'b0, tg[5:0], 1'b0, PPC_CPLR_ID, tg}));
      chk("low addr", 64'(desc[6:0]), 64'(t[1] ? 7'h0 : {ad[6:2], 2'h0}));
   endtask : rd
   // Hang guard, far past the several hundred cycles used
   initial begin
      #100000;
      miscompares++;
      close_out();
   end
   initial begin
      {cq_tdata, cq_tlast, cq_tvalid, reset_n} = '0;
      io_en = 1'b1;
      void'($urandom(32'h7f8f));
      repeat (3) @(negedge ref_clk);
      reset_n = 1'b1;
      for (int it = 0; it < 12; it++) begin
         idx = 9'($urandom);
         s = $urandom;
         a = {3'h0, idx, 2'($urandom)};
         foreach (hits[k]) req(PPC_REQ_MEM_WR, hits[k], a, PPC_ONE_DWORD, pat(hits[k], s), 8'h0);
         foreach (hits[k]) rd(PPC_REQ_MEM_RD, hits[k], a | 14'((k + 1) << 11), pat(hits[k], s));
      end
      $display("regions test done");
      n0 = ncpl;
      req(PPC_REQ_IO_WR, PPC_HIT_FIRST, 14'h0010, PPC_ONE_DWORD, 32'h1234_5678, 8'h5a);
      wcpl();
      chk("io wr keep", 64'(keep1), 64'(PPC_KEEP_DESC));
      chk("io wr dcnt", 64'(desc[42:32]), 64'h0);
      rd(PPC_REQ_IO_RD, PPC_HIT_FIRST, 14'h0010, 32'h1234_5678);
      $display("io test done");
      io_en = 1'b0;
      n0 = ncpl;
      req(PPC_REQ_IO_RD, PPC_HIT_FIRST, 14'h0010, PPC_ONE_DWORD, 32'h0, 8'h01);
      req(PPC_REQ_MEM_WR, PPC_HIT_FIRST, 14'h0010, 11'h002, 32'hffff_0000, 8'h02);
      req(PPC_REQ_MEM_RD, 3'h3, 14'h0010, PPC_ONE_DWORD, 32'h0, 8'h03);
      req(PPC_REQ_MEM_WR, PPC_HIT_WIDE, 14'h0020, PPC_ONE_DWORD, 32'h0, 8'h04);
      wcpl();
      chk("no cpl", 64'(ncpl), 64'(n0));
      io_en = 1'b1;
      rd(PPC_REQ_MEM_RD, PPC_HIT_FIRST, 14'h0010, 32'h1234_5678);
      $display("drop test done");
      req(PPC_REQ_MEM_WR, PPC_HIT_NARROW, 14'(PPC_OFS_INTR), PPC_ONE_DWORD, PPC_KEY_MSI, 8'h0);
      foreach (offs[k]) req(PPC_REQ_MEM_WR, PPC_HIT_FIRST, 14'(offs[k]), PPC_ONE_DWORD, keys[k], 8'h0);
      repeat (8) @(negedge ref_clk);
      foreach (pc[k]) chk("pulses", 64'(pc[k]), 64'h1);
      $display("trigger test done");
      close_out();
   end
endmodule : tb_top
bind ppc_completer ppc_chk_monitor u_mon (.ref_clk, .reset_n, .completer_request_ready_out, .cc_tdata, .cc_tkeep,
   .cc_tlast, .cc_tvalid, .cc_tready, .mem_read_start_pulse, .legacy_intr_pulse, .msi_pulse, .msix_pulse,
   .datapath_ok);
